// ===== common/sgu_map.svh
`ifndef SGU_MAP_SVH
`define SGU_MAP_SVH

// Register bus geometry
`define SGU_AW 4
`define SGU_DW 16

// Register indices on the plain register port
`define SGU_A_CTRL 4'h0
`define SGU_A_CAUSE 4'h1
`define SGU_A_SCR0 4'h2
`define SGU_A_SCR1 4'h3
`define SGU_A_SCR2 4'h4
`define SGU_A_SCR3 4'h5
`define SGU_A_IDH 4'h6
`define SGU_A_IDL 4'h7
`define SGU_A_PUD 4'h8
`define SGU_A_CKO 4'ha
`define SGU_A_GPS 4'hb
`define SGU_A_PCE 4'hc
`define SGU_A_ISH 4'hd
`define SGU_A_ISL 4'he
`define SGU_A_POPT 4'hf

// system_control fields
`define SGU_C_WDIS 0
`define SGU_C_SDIS 2
`define SGU_C_SWRST 4
`define SGU_C_DBGCLK 5

// reset_cause_status fields and values
`define SGU_R_POR 2
`define SGU_R_PIN_RESET_FLAG 3
`define SGU_R_WATCHDOG_RESET_FLAG 4
`define SGU_R_SWR 5
`define SGU_CAUSE_MASK 16'h003c
`define SGU_CAUSE_POR_VAL 16'h0004

// Writable masks, read-as-one fields, the Stop-mode CAN clock mask and the clock enable reset value
`define SGU_PUD_MASK 16'h7fa8
`define SGU_CKO_MASK 16'h03ff
`define SGU_GPS_MASK 16'h000f
`define SGU_ISH_RO 16'hfffc
`define SGU_PCE_CAN_MASK 16'h1000
`define SGU_PCE_RST 16'h0000

// power_option fields
`define SGU_PO_W 5
`define SGU_PO_WAIT_WD 0
`define SGU_PO_WAIT_PWM 1
`define SGU_PO_STOP_WD 2
`define SGU_PO_STOP_CAN 3
`define SGU_PO_DBG_PWM 4

// Core mode register
`define SGU_OMR_MA 0
`define SGU_OMR_WMASK 16'h81fb
`define SGU_OMR_RST 16'h0000
`define SGU_BOOT_SECURE 2'h0
`define SGU_CORE_EXC_EN 8'hff

// Reset extension counts in clock cycles
`define SGU_PHASE_CYC 32
`define SGU_EXT_CYC (3 * `SGU_PHASE_CYC)
`define SGU_POR_CYC (1 << 21)
`define SGU_RCNT_W 22

`endif

// ===== common/sgu_pkg.sv
package sgu_pkg;

  // Power modes of the device
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b10,
    MODE_DEBUG = 2'b11
  } sgu_mode_t;

  // Clock enables and mode-dependent forcing
  typedef struct packed {
    logic core;
    logic mem;
    logic [15:0] periph;
    logic wdog;
    logic pwm_off;
  } sgu_clk_t;

  // Phased reset outputs, active low resets
  typedef struct packed {
    logic clk_run;
    logic mem_n;
    logic sys_n;
  } sgu_rst_t;

  // Pin and address configuration registers
  typedef struct packed {
    logic [15:0] pud;
    logic [15:0] cko;
    logic [15:0] gps;
    logic [1:0] ish;
    logic [15:0] isl;
  } sgu_cfg_t;

endpackage

// ===== rtl/sgu_reset_stretch.sv
`timescale 1ns/1ps
`include "sgu_map.svh"

module sgu_reset_stretch #(
  parameter int POR_CYC = `SGU_POR_CYC,
  parameter int CW = `SGU_RCNT_W
) (
  input logic clk_sys_i,
  input logic resetn_i,
  input logic trig_i,
  output sgu_pkg::sgu_rst_t rst_o
);

  logic [CW-1:0] remain;

  // Load on power-on or another source, then count down to release
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      remain <= CW'(POR_CYC);
    end else if (trig_i) begin
      remain <= CW'(`SGU_EXT_CYC);
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // Clocks restart first, memories next, core and peripherals last
  assign rst_o.clk_run = remain <= CW'(2 * `SGU_PHASE_CYC);
  assign rst_o.mem_n = remain <= CW'(`SGU_PHASE_CYC);
  assign rst_o.sys_n = (remain == '0);

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  count_step_a: assert property (
    !trig_i && remain != '0 |=> remain == $past(remain) - 1'b1)
    else $error("reset count did not step");

  ext_load_a: assert property (
    $fell(trig_i) && $past(resetn_i) |-> remain == CW'(`SGU_EXT_CYC))
    else $error("short extension not loaded");

  por_load_a: assert property (
    $rose(resetn_i) |-> remain == CW'(POR_CYC))
    else $error("power-on extension not loaded");

  phase_order_a: assert property (
    $rose(rst_o.sys_n) |-> $past(rst_o.mem_n, 32)
      && !$past(rst_o.mem_n, 33))
    else $error("memory phase not 32 cycles before release");

endmodule

// ===== rtl/sgu_top.sv
`timescale 1ns/1ps
`include "sgu_map.svh"

module sgu_top #(
  parameter int POR_CYC = `SGU_POR_CYC,
  parameter logic [15:0] ID_HI = 16'h0a5c, // Arbitrary identity value
  parameter logic [15:0] ID_LO = 16'h3e71 // Arbitrary identity value
) (
  input logic clk_sys_i,
  input logic resetn_i,
  input logic [`SGU_AW-1:0] reg_addr_i,
  input logic [`SGU_DW-1:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  output logic [`SGU_DW-1:0] reg_rdata_o,
  input logic pin_resetn_i,
  input logic wdog_reset_i,
  input logic omr_wr_i,
  input logic [15:0] omr_wdata_i,
  output logic [15:0] omr_o,
  input logic [1:0] boot_strap_i,
  input logic flash_secure_i,
  input logic ext_bus_mode_i,
  input logic core_wait_i,
  input logic core_stop_i,
  input logic debug_req_i,
  input logic irq_wake_i,
  input logic can_wake_i,
  output sgu_pkg::sgu_mode_t mode_o,
  output sgu_pkg::sgu_clk_t clk_gate_o,
  output sgu_pkg::sgu_rst_t rst_o,
  output sgu_pkg::sgu_cfg_t cfg_o,
  output logic debug_clock_always_on_o,
  output logic flash_block_o,
  output logic intc_dflt_o,
  output logic [7:0] core_exc_en_o
);

  // Inhibit field decode: any non-zero code blocks the instruction
  function automatic logic inhibit(input logic [1:0] f);
    return f != 2'b00;
  endfunction

  // Codes 10 and 11 freeze the field until the next reset
  function automatic logic locked(input logic [1:0] f);
    return f[1];
  endfunction

  sgu_pkg::sgu_rst_t rst;
  sgu_pkg::sgu_mode_t mode;
  sgu_pkg::sgu_mode_t next_mode;
  logic [1:0] wdis;
  logic [1:0] sdis;
  logic dbg_clk;
  logic software_reset_trigger;
  logic trig;
  logic [15:0] cause;
  logic [15:0] next_cause;
  logic [15:0] scratch [4];
  logic [1:0] scr_idx;
  logic scr_hit;
  logic [15:0] pce;
  logic [`SGU_PO_W-1:0] popt;
  logic [15:0] rd_val;
  logic [1:0] boot_val;
  logic wr_ctrl;
  logic wr_cause;
  logic run_like;
  logic wdog_on;
  logic pwm_off;
  logic [15:0] stop_keep;

  // Address decode of the register port
  assign wr_ctrl = reg_wr_i && reg_addr_i == `SGU_A_CTRL;
  assign wr_cause = reg_wr_i && reg_addr_i == `SGU_A_CAUSE;
  assign scr_hit = reg_addr_i >= `SGU_A_SCR0
    && reg_addr_i <= `SGU_A_SCR3;
  assign scr_idx = 2'(reg_addr_i - `SGU_A_SCR0);

  // Every source other than power-on retriggers the short extension
  assign trig = !pin_resetn_i || wdog_reset_i || software_reset_trigger;

  sgu_reset_stretch #(
    .POR_CYC(POR_CYC),
    .CW(`SGU_RCNT_W)
  ) u_stretch (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .trig_i(trig),
    .rst_o(rst)
  );

  // Core and peripherals share the extended reset
  assign rst_o = rst;

  // Interrupt controller held in defaults while reset is extended
  assign intc_dflt_o = !rst.sys_n;
  assign core_exc_en_o = `SGU_CORE_EXC_EN;

  // Software reset trigger, a one-cycle pulse that never reads back
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      software_reset_trigger <= 1'b0;
    end else begin
      software_reset_trigger <= wr_ctrl && reg_wdata_i[`SGU_C_SWRST];
    end
  end

  // Control register; locked inhibit fields ignore writes
  always_ff @(posedge clk_sys_i) begin
    if (!rst.sys_n) begin
      wdis <= 2'b00;
      sdis <= 2'b00;
      dbg_clk <= 1'b0;
    end else if (wr_ctrl) begin
      if (!locked(wdis)) begin
        wdis <= reg_wdata_i[`SGU_C_WDIS +: 2];
      end
      if (!locked(sdis)) begin
        sdis <= reg_wdata_i[`SGU_C_SDIS +: 2];
      end
      dbg_clk <= reg_wdata_i[`SGU_C_DBGCLK];
    end
  end

  assign debug_clock_always_on_o = dbg_clk;

  // Cause flags: a write of zero sets, one clears; events win
  always_comb begin
    next_cause = cause;
    if (wr_cause) begin
      next_cause = ~reg_wdata_i & `SGU_CAUSE_MASK;
    end
    if (!pin_resetn_i) begin
      next_cause[`SGU_R_PIN_RESET_FLAG] = 1'b1;
    end
    if (wdog_reset_i) begin
      next_cause[`SGU_R_WATCHDOG_RESET_FLAG] = 1'b1;
    end
    if (software_reset_trigger) begin
      next_cause[`SGU_R_SWR] = 1'b1;
    end
  end

  // Only power-on reinitialises the cause flags
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cause <= `SGU_CAUSE_POR_VAL;
    end else begin
      cause <= next_cause;
    end
  end

  // Scratch words survive every reset but power-on
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++) begin
        scratch[i] <= 16'h0000;
      end
    end else if (reg_wr_i && scr_hit) begin
      scratch[scr_idx] <= reg_wdata_i;
    end
  end

  // Peripheral clock enables, all gated after reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst.sys_n) begin
      pce <= `SGU_PCE_RST;
    end else if (reg_wr_i && reg_addr_i == `SGU_A_PCE) begin
      pce <= reg_wdata_i;
    end
  end

  // Low-power and debug options
  always_ff @(posedge clk_sys_i) begin
    if (!rst.sys_n) begin
      popt <= '0;
    end else if (reg_wr_i && reg_addr_i == `SGU_A_POPT) begin
      popt <= reg_wdata_i[`SGU_PO_W-1:0];
    end
  end

  // Pin and address configuration registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst.sys_n) begin
      cfg_o <= '0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `SGU_A_PUD: cfg_o.pud <= reg_wdata_i & `SGU_PUD_MASK;
        `SGU_A_CKO: cfg_o.cko <= reg_wdata_i & `SGU_CKO_MASK;
        `SGU_A_GPS: cfg_o.gps <= reg_wdata_i & `SGU_GPS_MASK;
        `SGU_A_ISH: cfg_o.ish <= reg_wdata_i[1:0];
        `SGU_A_ISL: cfg_o.isl <= reg_wdata_i;
        default: cfg_o <= cfg_o;
      endcase
    end
  end

  // Boot bits reload from the flash security state or the straps
  assign boot_val = flash_secure_i ? `SGU_BOOT_SECURE : boot_strap_i;

  // Core mode register; watchdog and software resets keep the boot bit
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || !pin_resetn_i) begin
      omr_o <= `SGU_OMR_RST | {14'h0000, boot_val};
    end else if (wdog_reset_i || software_reset_trigger) begin
      omr_o <= `SGU_OMR_RST
        | {14'h0000, boot_val[1], omr_o[`SGU_OMR_MA]};
    end else if (omr_wr_i) begin
      omr_o <= omr_wdata_i & `SGU_OMR_WMASK;
    end
  end

  // Mode sequencing; the PLL is left to software before Stop
  always_comb begin
    next_mode = mode;
    unique case (mode)
      sgu_pkg::MODE_RUN: begin
        if (debug_req_i) begin
          next_mode = sgu_pkg::MODE_DEBUG;
        end else if (core_stop_i && !inhibit(sdis)) begin
          next_mode = sgu_pkg::MODE_STOP;
        end else if (core_wait_i && !inhibit(wdis)) begin
          next_mode = sgu_pkg::MODE_WAIT;
        end
      end
      sgu_pkg::MODE_WAIT: begin
        if (debug_req_i) begin
          next_mode = sgu_pkg::MODE_DEBUG;
        end else if (irq_wake_i) begin
          next_mode = sgu_pkg::MODE_RUN;
        end
      end
      sgu_pkg::MODE_STOP: begin
        if (irq_wake_i || can_wake_i) begin
          next_mode = sgu_pkg::MODE_RUN;
        end
      end
      sgu_pkg::MODE_DEBUG: begin
        if (!debug_req_i) begin
          next_mode = sgu_pkg::MODE_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst.sys_n) begin
      mode <= sgu_pkg::MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  assign mode_o = mode;

  // Per-mode watchdog and PWM treatment
  always_comb begin
    wdog_on = 1'b1;
    pwm_off = 1'b0;
    unique case (mode)
      sgu_pkg::MODE_RUN: begin
        wdog_on = 1'b1;
      end
      sgu_pkg::MODE_WAIT: begin
        wdog_on = !popt[`SGU_PO_WAIT_WD];
        pwm_off = popt[`SGU_PO_WAIT_PWM];
      end
      sgu_pkg::MODE_STOP: begin
        wdog_on = !popt[`SGU_PO_STOP_WD];
      end
      sgu_pkg::MODE_DEBUG: begin
        wdog_on = 1'b0;
        pwm_off = popt[`SGU_PO_DBG_PWM];
      end
    endcase
  end

  assign run_like = mode == sgu_pkg::MODE_RUN
    || mode == sgu_pkg::MODE_DEBUG;
  assign stop_keep = popt[`SGU_PO_STOP_CAN] ? 16'h0000
    : `SGU_PCE_CAN_MASK;

  // Clock gates, all off until the clock phase of the reset tail
  always_ff @(posedge clk_sys_i) begin
    if (!rst.clk_run) begin
      clk_gate_o <= '0;
    end else begin
      clk_gate_o.core <= run_like;
      clk_gate_o.mem <= run_like;
      clk_gate_o.periph <= (mode == sgu_pkg::MODE_STOP)
        ? (pce & stop_keep) : pce;
      clk_gate_o.wdog <= wdog_on;
      clk_gate_o.pwm_off <= pwm_off;
    end
  end

  // Secured flash is fenced off from the debug port
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      flash_block_o <= 1'b1;
    end else begin
      flash_block_o <= flash_secure_i
        && (debug_req_i || mode == sgu_pkg::MODE_DEBUG);
    end
  end

  // Read multiplexer
  always_comb begin
    rd_val = 16'h0000;
    case (reg_addr_i)
      `SGU_A_CTRL: rd_val = {9'h000, ext_bus_mode_i, dbg_clk,
        1'b0, sdis, wdis};
      `SGU_A_CAUSE: rd_val = cause;
      `SGU_A_SCR0, `SGU_A_SCR1, `SGU_A_SCR2, `SGU_A_SCR3:
        rd_val = scratch[scr_idx];
      `SGU_A_IDH: rd_val = ID_HI;
      `SGU_A_IDL: rd_val = ID_LO;
      `SGU_A_PUD: rd_val = cfg_o.pud;
      `SGU_A_CKO: rd_val = cfg_o.cko;
      `SGU_A_GPS: rd_val = cfg_o.gps;
      `SGU_A_PCE: rd_val = pce;
      `SGU_A_ISH: rd_val = `SGU_ISH_RO | {14'h0000, cfg_o.ish};
      `SGU_A_ISL: rd_val = cfg_o.isl;
      `SGU_A_POPT: rd_val = {11'h000, popt};
      default: rd_val = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_val;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  software_reset_trigger_zero_a: assert property (
    reg_rd_i && reg_addr_i == `SGU_A_CTRL |=> !reg_rdata_o[`SGU_C_SWRST])
    else $error("software reset bit read back as one");

  software_reset_trigger_fire_a: assert property (
    wr_ctrl && reg_wdata_i[`SGU_C_SWRST] |-> ##2 !rst_o.sys_n)
    else $error("software reset did not reset the device");

  stop_block_a: assert property (
    rst.sys_n && mode == sgu_pkg::MODE_RUN && core_stop_i
      && !debug_req_i && inhibit(sdis)
      |=> mode != sgu_pkg::MODE_STOP)
    else $error("inhibited stop was entered");

  inhib_lock_a: assert property (
    rst.sys_n && locked(sdis) |=> sdis == $past(sdis))
    else $error("locked stop inhibit changed");

  wait_clock_a: assert property (
    rst.clk_run && mode == sgu_pkg::MODE_WAIT
      |=> !clk_gate_o.core && !clk_gate_o.mem
        && clk_gate_o.periph == $past(pce))
    else $error("wait mode clock gating wrong");

  debug_wdog_a: assert property (
    rst.clk_run && mode == sgu_pkg::MODE_DEBUG |=> !clk_gate_o.wdog)
    else $error("watchdog running in debug mode");

  stop_wake_a: assert property (
    rst.sys_n && mode == sgu_pkg::MODE_STOP
      && (irq_wake_i || can_wake_i) |=> mode == sgu_pkg::MODE_RUN)
    else $error("stop mode did not wake");

  scratch_keep_a: assert property (
    !(reg_wr_i && scr_hit) |=> scratch[0] == $past(scratch[0]))
    else $error("scratch word changed without a write");

  cause_por_a: assert property (
    $rose(resetn_i) |-> cause == `SGU_CAUSE_POR_VAL)
    else $error("cause flags not initialised by power-on");

  cause_keep_a: assert property (
    wdog_reset_i && !wr_cause
      |=> cause[`SGU_R_WATCHDOG_RESET_FLAG] && ($past(cause) & ~cause) == 16'h0000)
    else $error("watchdog reset cleared another cause");

  boot_keep_a: assert property (
    wdog_reset_i && pin_resetn_i
      |=> omr_o[`SGU_OMR_MA] == $past(omr_o[`SGU_OMR_MA]))
    else $error("boot bit changed by watchdog reset");

endmodule

// ===== testbench/sgu_core_model.sv
`timescale 1ns/1ps

// Core side: turns bench commands into wait and stop instruction pulses
module sgu_core_model (
  input wire logic clk_sys_i,
  input wire logic wait_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic wake_i,
  output logic core_wait_o = 1'b0,
  output logic core_stop_o = 1'b0,
  output logic pll_on_o = 1'b1
);
  // Idle values come from the declarations, so each output has one process
  logic stop_pend = 1'b0;

  // Stop is issued one cycle after the PLL has been shut down by software
  always @(posedge clk_sys_i) begin
    core_wait_o <= wait_cmd_i;
    stop_pend <= stop_cmd_i;
    core_stop_o <= stop_pend;
    if (stop_cmd_i) begin
      pll_on_o <= 1'b0;
    end else if (wake_i) begin
      pll_on_o <= 1'b1;
    end
  end
endmodule

// ===== testbench/sgu_top_tb.sv
`timescale 1ns/1ps
`include "sgu_map.svh"

module sgu_top_tb;
  localparam int POR = 200;
  localparam logic [15:0] IDH = 16'h1234; // Arbitrary identity value
  localparam logic [15:0] IDL = 16'h5678; // Arbitrary identity value
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] omr_wdata = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] core_operating_mode;
  logic wr = 1'b0, rd = 1'b0, pin_n = 1'b1, wdog = 1'b0, omr_wr = 1'b0;
  logic secure = 1'b0, busm = 1'b1, dbg = 1'b0, irq = 1'b0, can = 1'b0;
  logic wait_cmd = 1'b0, stop_cmd = 1'b0, core_wait, core_stop;
  logic [1:0] strap = 2'h2;
  sgu_pkg::sgu_mode_t mode;
  sgu_pkg::sgu_clk_t gate;
  sgu_pkg::sgu_rst_t rst;
  sgu_pkg::sgu_cfg_t cfg;
  logic dclk, pll;
  logic fblock, intc;
  logic [7:0] exc;
  int errors = 0;
  int total_checks = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  sgu_core_model core (.clk_sys_i(clk_sys_i), .wait_cmd_i(wait_cmd),
    .stop_cmd_i(stop_cmd), .wake_i(irq | can), .core_wait_o(core_wait),
    .core_stop_o(core_stop), .pll_on_o(pll));

  sgu_top #(.POR_CYC(POR), .ID_HI(IDH), .ID_LO(IDL)) dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pin_resetn_i(pin_n), .wdog_reset_i(wdog), .omr_wr_i(omr_wr),
    .omr_wdata_i(omr_wdata), .omr_o(core_operating_mode), .boot_strap_i(strap),
    .flash_secure_i(secure), .ext_bus_mode_i(busm),
    .core_wait_i(core_wait), .core_stop_i(core_stop), .debug_req_i(dbg),
    .irq_wake_i(irq), .can_wake_i(can), .mode_o(mode), .clk_gate_o(gate),
    .rst_o(rst), .cfg_o(cfg), .debug_clock_always_on_o(dclk),
    .flash_block_o(fblock), .intc_dflt_o(intc), .core_exc_en_o(exc));

  // Compare and count
  task check(input string name, input logic [19:0] seen,
             input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // One-cycle register write
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  // Read strobe, data taken in the following cycle only
  task rd_chk(input string name, input logic [3:0] a,
              input logic [15:0] exp);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask

  task scr_chk(input bit keep);
    for (int i = 0; i < 4; i++) begin
      rd_chk("scratch", 4'(`SGU_A_SCR0 + i),
        keep ? 16'ha5a0 + 16'(i) : 16'h0000);
    end
  endtask

  task pulse(input bit s);
    @(posedge clk_sys_i);
    if (s) stop_cmd <= 1'b1;
    else wait_cmd <= 1'b1;
    @(posedge clk_sys_i);
    stop_cmd <= 1'b0;
    wait_cmd <= 1'b0;
  endtask

  // Counts the extension and the phase leads of clocks and memories
  task wait_release(input int total);
    int n, c_at, m_at;
    n = 0;
    c_at = -1;
    m_at = -1;
    while (rst.sys_n !== 1'b1 && n < 5000) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (rst.clk_run === 1'b1 && c_at < 0) c_at = n;
      if (rst.mem_n === 1'b1 && m_at < 0) m_at = n;
    end
    check("clock lead", 20'(n - c_at), 20'd64);
    check("memory lead", 20'(n - m_at), 20'd32);
    if (total > 0) check("extension", 20'(n), 20'(total));
  endtask

  // Waits for a non power-on source to take hold, then for release
  task src_reset;
    int k;
    k = 0;
    while (rst.sys_n === 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    check("reset taken", rst, 3'b000);
    wait_release(0);
  endtask

  task test_done(input string s);
    $display("test %s done", s);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #(25 * 6000);
    errors++;
    $display("watchdog expired");
    give_verdict;
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    #1;
    check("intc default", intc, 1'b1);
    check("core exceptions", exc, 8'hff);
    wait_release(POR);
    check("intc default", intc, 1'b0);
    rd_chk("cause", `SGU_A_CAUSE, 16'h0004);
    rd_chk("control", `SGU_A_CTRL, 16'h0040);
    check("mode register", core_operating_mode, 16'h0002);
    rd_chk("id high", `SGU_A_IDH, IDH);
    rd_chk("id low", `SGU_A_IDL, IDL);
    wr_reg(4'h9, 16'hffff);
    rd_chk("hole", 4'h9, 16'h0000);
    wr_reg(`SGU_A_CTRL, 16'h0020);
    wr_reg(`SGU_A_PUD, 16'hffff);
    wr_reg(`SGU_A_ISH, 16'h0003);
    rd_chk("control", `SGU_A_CTRL, 16'h0060);
    check("debug clock", dclk, 1'b1);
    rd_chk("pullup", `SGU_A_PUD, 16'h7fa8);
    rd_chk("short high", `SGU_A_ISH, 16'hffff);
    check("cfg pullup", cfg.pud, 16'h7fa8);
    for (int i = 0; i < 4; i++) wr_reg(4'(`SGU_A_SCR0 + i), 16'ha5a0 + 16'(i));
    scr_chk(1'b1);
    check("gate", gate, {2'b11, 16'h0000, 2'b10});
    wr_reg(`SGU_A_PCE, 16'h1003);
    wr_reg(`SGU_A_POPT, 16'h001f);
    rd_chk("options", `SGU_A_POPT, 16'h001f);
    cyc(3);
    check("gate", gate, {2'b11, 16'h1003, 2'b10});
    test_done("registers");
    wr_reg(`SGU_A_CTRL, 16'h0001);
    pulse(1'b0);
    cyc(4);
    check("mode", mode, sgu_pkg::MODE_RUN);
    wr_reg(`SGU_A_CTRL, 16'h0000);
    pulse(1'b0);
    cyc(4);
    check("mode", mode, sgu_pkg::MODE_WAIT);
    check("gate", gate, {2'b00, 16'h1003, 2'b01});
    irq <= 1'b1;
    cyc(4);
    check("mode", mode, sgu_pkg::MODE_RUN);
    irq <= 1'b0;
    pulse(1'b1);
    cyc(5);
    check("mode", mode, sgu_pkg::MODE_STOP);
    check("pll", pll, 1'b0);
    check("gate", {gate[19:1], 1'b0}, 20'h0);
    can <= 1'b1;
    cyc(4);
    check("mode", mode, sgu_pkg::MODE_RUN);
    can <= 1'b0;
    dbg <= 1'b1;
    cyc(4);
    check("mode", mode, sgu_pkg::MODE_DEBUG);
    check("gate", gate, {2'b11, 16'h1003, 2'b01});
    check("flash fence", fblock, 1'b0);
    dbg <= 1'b0;
    cyc(4);
    check("mode", mode, sgu_pkg::MODE_RUN);
    wr_reg(`SGU_A_CTRL, 16'h000b);
    wr_reg(`SGU_A_CTRL, 16'h0000);
    rd_chk("control", `SGU_A_CTRL, 16'h004b);
    pulse(1'b1);
    cyc(5);
    check("mode", mode, sgu_pkg::MODE_RUN);
    pulse(1'b0);
    cyc(4);
    check("mode", mode, sgu_pkg::MODE_RUN);
    test_done("modes");
    @(posedge clk_sys_i);
    omr_wr <= 1'b1;
    omr_wdata <= 16'h0101;
    @(posedge clk_sys_i);
    omr_wr <= 1'b0;
    wr_reg(`SGU_A_CTRL, 16'h0010);
    src_reset;
    rd_chk("control", `SGU_A_CTRL, 16'h0040);
    rd_chk("cause", `SGU_A_CAUSE, 16'h0024);
    check("mode register", core_operating_mode, 16'h0003);
    scr_chk(1'b1);
    @(posedge clk_sys_i);
    wdog <= 1'b1;
    @(posedge clk_sys_i);
    wdog <= 1'b0;
    src_reset;
    rd_chk("cause", `SGU_A_CAUSE, 16'h0034);
    test_done("soft resets");
    @(posedge clk_sys_i);
    secure <= 1'b1;
    pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    pin_n <= 1'b1;
    src_reset;
    rd_chk("cause", `SGU_A_CAUSE, 16'h003c);
    check("mode register", core_operating_mode, 16'h0000);
    check("gate", gate, {2'b11, 16'h0000, 2'b10});
    check("cfg pullup", cfg.pud, 16'h0000);
    scr_chk(1'b1);
    dbg <= 1'b1;
    cyc(4);
    check("flash fence", fblock, 1'b1);
    dbg <= 1'b0;
    test_done("pin reset");
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    #1;
    wait_release(POR);
    scr_chk(1'b0);
    rd_chk("cause", `SGU_A_CAUSE, 16'h0004);
    test_done("power-on again");
    give_verdict;
  end
endmodule
